/* video_timing_pkg.sv */
// constants and types for the panel video output timing block
// What the document requires of this block, its trigger source and its receiver
// RQ1: each frame is a virtual frame: real image inside four blanking strips.
// RQ2: every blanking strip, vertical or horizontal, is at least four pixels.
// RQ3: top and left blanking are much shorter than bottom and right blanking.
// RQ4: vertical sync marks vertical frame edges, horizontal sync marks line edges.
// RQ5: forwarded pixel clock period 25 to 31.25 ns, duty 40 to 60 percent.
// RQ6: vertical sync low at frame corner for 2 to 8 lines, then high.
// RQ7: vertical sync falls in the same pixel clock as horizontal sync.
// RQ8: horizontal sync low at line start for 2 to 8 clocks, then high.
// RQ9: data-valid high in blanking, low while image or clamp data is driven.
// RQ10: data-valid stays low without gaps across the real image area.
// RQ11: fluoroscopy frame is 800 lines, 768 of them image, about 41.66 us each.
// RQ12: fluoroscopy line is 1333 clocks, sync low 8, high 1325, valid offset 7.
// RQ13: full-resolution line is 2560 clocks, sync low 8, high 2552, about 80 us.
// RQ14: in user-sync mode an external trigger starts frames, bypassing the internal loop.
// RQ15: further triggers are ignored until the real frame output has finished.
// RQ16: internal timing locks to the rising edge of the external trigger.
// RQ17: trigger rate stays below 30 Hz fluoroscopy and 7.5 Hz full resolution.
// RQ18: fluoroscopy bins 2x2 to 1024/768; full resolution gives 2048/1536 unbinned.
// RQ19: the trigger source keeps its line free of glitches.
// RQ20: the receiver samples syncs, valid and data on the rising pixel clock edge.
// RQ21: the video output carries up to sixteen data bits per pixel clock.
// RQ22: line sync pulses continue at the normal period through vertical blanking; the code stops them in ST_IDLE between frames.
// RQ23: sync and valid come from free-running counters restarted on each accepted frame.
package video_timing_pkg;

	// ****************************************
	// widths and timing
	// ****************************************
	localparam int unsigned DATA_W          = 16;  // [RQ21]
	localparam int unsigned CNT_W           = 12;
	localparam int unsigned HSYNC_LOW_CLKS  = 8;   // [RQ8]
	localparam int unsigned VALID_OFS_CLKS  = 7;
	localparam int unsigned VSYNC_LOW_LINES = 4;   // [RQ6]
	localparam int unsigned MIN_BLANK       = 4;   // [RQ2]
	localparam int unsigned TOP_BLANK_LINES = 7;
	localparam int unsigned LINE_IDLE_CLKS  = 1;

	// fluoroscopy, binned 2x2
	localparam int unsigned FL_LINE_CLKS  = 1333;  // [RQ12]
	localparam int unsigned FL_FRAME_LNS  = 800;   // [RQ11]
	localparam int unsigned FL_IMG_LINES  = 768;
	localparam int unsigned FL_IMG_PIXELS = 1024;  // [RQ18]

	// full resolution, unbinned
	localparam int unsigned FR_LINE_CLKS  = 2560;  // [RQ13]
	// 7 top plus 368 bottom lines give about 30 ms of vertical blank
	localparam int unsigned FR_FRAME_LNS  = 1911;  // [RQ18]
	localparam int unsigned FR_IMG_LINES  = 1536;
	localparam int unsigned FR_IMG_PIXELS = 2048;  // [RQ18]

	// ****************************************
	// types
	// ****************************************
	typedef enum logic {MODE_FLUORO, MODE_FULL_RES} res_mode_t;

	typedef enum logic [1:0] {ST_IDLE, ST_FRAME, ST_TAIL} frame_state_t;

	typedef struct packed {
		logic [CNT_W-1:0] line_clks;
		logic [CNT_W-1:0] frame_lines;
		logic [CNT_W-1:0] img_lines;
		logic [CNT_W-1:0] img_pixels;
	} geom_t;

	typedef struct packed {
		logic              vsync_n;
		logic              hsync_n;
		logic              qual_n;
		logic [DATA_W-1:0] data;
	} video_bus_t;

	localparam logic [CNT_W-1:0] CNT_ONE = 12'h001;

endpackage : video_timing_pkg

/* sync_level.sv */
// two-flop level synchroniser
`timescale 1ns/1ps
module sync_level
	import video_timing_pkg::*;
#(
	parameter int unsigned W = 1
)(
	input  wire logic         clk,
	input  wire logic         arst_n,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_ff;

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			meta_ff <= '0;
			q       <= '0;
		end
		else
		begin
			meta_ff <= d;
			q       <= meta_ff;
		end
	end
endmodule : sync_level

/* panel_video_out_timing.sv */
// video framing generator on the pixel clock, fed from the system clock
`timescale 1ns/1ps
module panel_video_out_timing
	import video_timing_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              arst_n,
	input  wire logic              pel_clk,
	input  wire logic              user_sync_en,
	input  wire logic              full_res,
	input  wire logic              frame_trig,
	input  wire logic              int_frame_start,
	input  wire logic [DATA_W-1:0] pixel_data,
	output logic                   pixel_req,
	output logic                   frame_busy,
	output logic                   forwarded_pel_clock,
	output video_bus_t             video_out
);
	// ****************************************
	// pin inputs into the pixel clock domain
	// ****************************************
	// reset released synchronously on the pixel clock
	logic pel_rst_meta_ff;
	logic pel_rst_n_ff;

	always_ff @(posedge pel_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			pel_rst_meta_ff <= 1'b0;
			pel_rst_n_ff    <= 1'b0;
		end
		else
		begin
			pel_rst_meta_ff <= 1'b1;
			pel_rst_n_ff    <= pel_rst_meta_ff;
		end
	end

	// internal start pulse from clk domain crosses as a toggle
	logic int_tgl_ff;

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			int_tgl_ff <= 1'b0;
		else if (int_frame_start)
			int_tgl_ff <= ~int_tgl_ff;
	end

	logic [3:0] sync_d;
	logic [3:0] sync_q;
	wire        trig_s     = sync_q[0];
	wire        int_tgl_s  = sync_q[1];
	wire        user_en_s  = sync_q[2];
	wire        full_res_s = sync_q[3];

	assign sync_d = {full_res, user_sync_en, int_tgl_ff, frame_trig};

	sync_level #(
		.W (4)
	) u_sync (
		.clk    (pel_clk),
		.arst_n (pel_rst_n_ff),
		.d      (sync_d),
		.q      (sync_q)
	);

	// ****************************************
	// frame start selection
	// ****************************************
	logic trig_prev_ff;
	logic int_prev_ff;

	always_ff @(posedge pel_clk or negedge pel_rst_n_ff)
	begin
		if (!pel_rst_n_ff)
		begin
			trig_prev_ff <= 1'b0;
			int_prev_ff  <= 1'b0;
		end
		else
		begin
			trig_prev_ff <= trig_s;
			int_prev_ff  <= int_tgl_s;
		end
	end

	wire trig_rise  = trig_s & ~trig_prev_ff;  // [RQ16]
	wire int_event  = int_tgl_s ^ int_prev_ff;
	// user sync bypasses the internal start path entirely
	wire start_req  = user_en_s ? trig_rise : int_event;  // [RQ14]

	// ****************************************
	// geometry
	// ****************************************
	function automatic geom_t geom_of(input logic fr);
		geom_t g;
		g = '0;
		if (fr)
		begin
			g.line_clks   = CNT_W'(FR_LINE_CLKS);
			g.frame_lines = CNT_W'(FR_FRAME_LNS);
			g.img_lines   = CNT_W'(FR_IMG_LINES);
			g.img_pixels  = CNT_W'(FR_IMG_PIXELS);
		end
		else
		begin
			g.line_clks   = CNT_W'(FL_LINE_CLKS);
			g.frame_lines = CNT_W'(FL_FRAME_LNS);
			g.img_lines   = CNT_W'(FL_IMG_LINES);
			g.img_pixels  = CNT_W'(FL_IMG_PIXELS);
		end
		return g;
	endfunction : geom_of

	// mode is latched per frame so a mid-frame change cannot tear a line
	logic  mode_ff;
	geom_t geom;

	assign geom = geom_of(mode_ff);

	// ****************************************
	// frame state and counters
	// ****************************************
	frame_state_t     state_ff;
	frame_state_t     nxt_state;
	logic [CNT_W-1:0] pix_ff;
	logic [CNT_W-1:0] line_ff;

	wire line_end  = (pix_ff == geom.line_clks - CNT_ONE);
	wire frame_end = line_end & (line_ff == geom.frame_lines - CNT_ONE);
	// image lines sit after a short top strip, leaving a long bottom strip [RQ3]
	wire img_row   = (line_ff >= CNT_W'(TOP_BLANK_LINES))
		& (line_ff < CNT_W'(TOP_BLANK_LINES) + geom.img_lines);  // [RQ1]
	wire last_row  = (line_ff == CNT_W'(TOP_BLANK_LINES) + geom.img_lines - CNT_ONE);
	// left strip is the sync width plus offset, right strip takes the rest
	wire img_col   = (pix_ff >= CNT_W'(HSYNC_LOW_CLKS + VALID_OFS_CLKS))
		& (pix_ff < CNT_W'(HSYNC_LOW_CLKS + VALID_OFS_CLKS) + geom.img_pixels);  // [RQ2]
	wire real_done = last_row & line_end;
	// a trigger is honoured only while no real frame is being sent
	wire accept    = start_req & (state_ff != ST_FRAME);  // [RQ15]

	always_comb
	begin
		nxt_state = state_ff;
		case (state_ff)
			ST_IDLE:
				if (accept)
					nxt_state = ST_FRAME;
			ST_FRAME:
				if (real_done)
					nxt_state = ST_TAIL;
			ST_TAIL:
				if (accept)
					nxt_state = ST_FRAME;
				else if (frame_end)
					nxt_state = ST_IDLE;
			default:
				nxt_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge pel_clk or negedge pel_rst_n_ff)
	begin
		if (!pel_rst_n_ff)
			state_ff <= ST_IDLE;
		else
			state_ff <= nxt_state;
	end

	always_ff @(posedge pel_clk or negedge pel_rst_n_ff)
	begin
		if (!pel_rst_n_ff)
			mode_ff <= MODE_FLUORO;
		else if (accept)
			mode_ff <= full_res_s;
	end

	// counters run free and restart on each accepted frame [RQ23]
	always_ff @(posedge pel_clk or negedge pel_rst_n_ff)
	begin
		if (!pel_rst_n_ff)
			pix_ff <= '0;
		else if (accept || line_end)
			pix_ff <= '0;
		else
			pix_ff <= pix_ff + CNT_ONE;
	end

	always_ff @(posedge pel_clk or negedge pel_rst_n_ff)
	begin
		if (!pel_rst_n_ff)
			line_ff <= '0;
		else if (accept || frame_end)
			line_ff <= '0;
		else if (line_end)
			line_ff <= line_ff + CNT_ONE;
	end

	// ****************************************
	// sync and qualifier generation
	// ****************************************
	wire active    = (state_ff != ST_IDLE);
	// line sync runs through the top and bottom blanking strips but stops in ST_IDLE [RQ22]
	wire hs_low    = active & (pix_ff < CNT_W'(HSYNC_LOW_CLKS));  // [RQ8] [RQ12] [RQ13]
	// same counter origin makes both syncs fall on one edge [RQ7]
	wire vs_low    = active & (line_ff < CNT_W'(VSYNC_LOW_LINES));  // [RQ6] [RQ4]
	wire img_pix   = (state_ff == ST_FRAME) & img_row & img_col;  // [RQ9] [RQ10]

	assign pixel_req  = img_pix;
	assign frame_busy = (state_ff == ST_FRAME);

	always_ff @(posedge pel_clk or negedge pel_rst_n_ff)
	begin
		if (!pel_rst_n_ff)
			video_out <= '{vsync_n: 1'b1, hsync_n: 1'b1, qual_n: 1'b1, data: '0};
		else
		begin
			video_out.vsync_n <= ~vs_low;
			video_out.hsync_n <= ~hs_low;
			video_out.qual_n  <= ~img_pix;  // [RQ9]
			video_out.data    <= img_pix ? pixel_data : '0;  // [RQ21]
		end
	end

	// ****************************************
	// forwarded clock
	// ****************************************
	// outputs change on the rising edge; forwarding the inverted clock puts
	// the receiver's rising edge mid-bit at the same period, high and low times swapped [RQ5] [RQ20]
	assign forwarded_pel_clock = ~pel_clk;

endmodule : panel_video_out_timing

/* video_out_checker_assertions.sv */
// concurrent checks on the video framing outputs
`timescale 1ns/1ps
module video_out_checker
	import video_timing_pkg::*;
(
	input wire logic              clk,
	input wire logic              arst_n,
	input wire logic              pel_clk,
	input wire logic              user_sync_en,
	input wire logic              full_res,
	input wire logic              frame_trig,
	input wire logic              int_frame_start,
	input wire logic [DATA_W-1:0] pixel_data,
	input wire logic              pixel_req,
	input wire logic              frame_busy,
	input wire logic              forwarded_pel_clock,
	input wire video_bus_t        video_out
);
	// ****
	// line, run and vsync counters
	// ****
	logic [CNT_W-1:0] l_cnt_ff;
	logic [CNT_W-1:0] q_run_ff;
	logic [3:0]       vs_hs_ff;
	logic             hs_q_ff;
	wire              hs_fall = hs_q_ff & ~video_out.hsync_n;

	always_ff @(posedge pel_clk or negedge arst_n)
		if (!arst_n)
		begin
			l_cnt_ff <= '0;
			q_run_ff <= '0;
			vs_hs_ff <= 4'h0;
			hs_q_ff  <= 1'b1;
		end
		else
		begin
			l_cnt_ff <= hs_fall ? CNT_ONE : l_cnt_ff + CNT_ONE;
			q_run_ff <= video_out.qual_n ? '0 : q_run_ff + CNT_ONE;
			vs_hs_ff <= video_out.vsync_n ? 4'h0 : vs_hs_ff + {3'h0, hs_fall};
			hs_q_ff  <= video_out.hsync_n;
		end

	default clocking @(posedge pel_clk); endclocking
	default disable iff (!arst_n);

	a_vs_with_hs: assert property ($fell(video_out.vsync_n) |-> $fell(video_out.hsync_n))
		else $error("vsync fell apart from hsync");
	a_hs_low_len: assert property ($fell(video_out.hsync_n) |->
		!video_out.hsync_n [*8] ##1 video_out.hsync_n) else $error("hsync low length");
	a_data_follow: assert property (pixel_req |=>
		video_out.data == $past(pixel_data) && !video_out.qual_n) else $error("data word lost");
	a_qual_blank: assert property (!video_out.qual_n |-> video_out.hsync_n && video_out.vsync_n)
		else $error("valid during sync");
	a_qual_run: assert property ($rose(video_out.qual_n) |->
		q_run_ff == (full_res ? 12'h800 : 12'h400)) else $error("valid run length");
	a_line_len: assert property (hs_fall && !$fell(video_out.vsync_n) |->
		l_cnt_ff == (full_res ? 12'ha00 : 12'h535)) else $error("line length");
	a_vs_lines: assert property ($rose(video_out.vsync_n) |-> vs_hs_ff == 4'h4)
		else $error("vsync line count");
	a_busy_hold: assert property (frame_busy && $past(frame_busy, 2) |-> !$fell(video_out.vsync_n))
		else $error("frame restarted while busy");
	a_trig_start: assert property (user_sync_en && $rose(frame_trig) && !frame_busy |->
		##[2:8] $fell(video_out.vsync_n)) else $error("trigger not followed by frame");
endmodule : video_out_checker

bind panel_video_out_timing video_out_checker chk_u (.clk(clk), .arst_n(arst_n),
	.pel_clk(pel_clk), .user_sync_en(user_sync_en), .full_res(full_res),
	.frame_trig(frame_trig), .int_frame_start(int_frame_start), .pixel_data(pixel_data),
	.pixel_req(pixel_req), .frame_busy(frame_busy),
	.forwarded_pel_clock(forwarded_pel_clock), .video_out(video_out));

/* rx_model.sv */
// receiver model: measures the video bus on the forwarded clock
`timescale 1ns/1ps
module rx_model
	import video_timing_pkg::*;
(
	input wire logic       forwarded_pel_clock,
	input wire video_bus_t video_out,
	output int             line_len,
	output int             hs_low,
	output int             vs_lines,
	output int             vs_falls,
	output int             q_ofs,
	output int             q_run,
	output int             q_line
);
	logic hs_q = 1'b1;
	logic vs_q = 1'b1;
	logic q_q  = 1'b1;
	int   cnt  = 0;
	int   hrun = 0;
	int   qrun = 0;
	int   lines = 0;

	// sampled on the rising forwarded edge
	always @(posedge forwarded_pel_clock)
	begin
		cnt++;
		if (vs_q && !video_out.vsync_n)
		begin
			vs_falls++;
			lines = 0;
			vs_lines = 0;
			q_line = 0;
		end
		if (hs_q && !video_out.hsync_n)
		begin
			line_len = cnt;
			cnt = 0;
			lines++;
			if (!video_out.vsync_n)
				vs_lines++;
		end
		if (!hs_q && video_out.hsync_n)
			hs_low = hrun;
		if (!q_q && video_out.qual_n)
			q_run = qrun;
		if (q_q && !video_out.qual_n)
		begin
			q_ofs = cnt;
			if (q_line == 0)
				q_line = lines;
		end
		hrun = video_out.hsync_n ? 0 : hrun + 1;
		qrun = video_out.qual_n ? 0 : qrun + 1;
		hs_q = video_out.hsync_n;
		vs_q = video_out.vsync_n;
		q_q  = video_out.qual_n;
	end
endmodule : rx_model

/* tb_top.sv */
// testbench for the panel video framing block
`timescale 1ns/1ps
module tb_top
	import video_timing_pkg::*;
;
	logic              clk = 0, pel_clk = 0, arst_n = 0;
	logic              user_sync_en = 0, full_res = 0, frame_trig = 0, int_frame_start = 0;
	logic [DATA_W-1:0] pixel_data = 16'h0000;
	logic              pixel_req, frame_busy, forwarded_pel_clock;
	video_bus_t        video_out;
	int                err_total = 0, compares = 0, seed = 32'h50274cf9;
	int                line_len, hs_low, vs_lines, vs_falls, q_ofs, q_run, q_line;

	always #25 clk = ~clk;
	always #32 pel_clk = ~pel_clk;
	always @(posedge pel_clk) pixel_data <= 16'($random(seed));

	panel_video_out_timing dut_u (.clk(clk), .arst_n(arst_n), .pel_clk(pel_clk),
		.user_sync_en(user_sync_en), .full_res(full_res), .frame_trig(frame_trig),
		.int_frame_start(int_frame_start), .pixel_data(pixel_data), .pixel_req(pixel_req),
		.frame_busy(frame_busy), .forwarded_pel_clock(forwarded_pel_clock),
		.video_out(video_out));
	rx_model rx_u (.forwarded_pel_clock(forwarded_pel_clock), .video_out(video_out),
		.line_len(line_len), .hs_low(hs_low), .vs_lines(vs_lines), .vs_falls(vs_falls),
		.q_ofs(q_ofs), .q_run(q_run), .q_line(q_line));

	function automatic logic [31:0] exp_len(input logic m);
		return m ? 32'h00000a00 : 32'h00000535;
	endfunction : exp_len
	function automatic logic [31:0] exp_pix(input logic m);
		return m ? 32'h00000800 : 32'h00000400;
	endfunction : exp_pix

	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk

	// a word presented before an edge must leave on the bus at that edge
	logic [DATA_W-1:0] exp_word_ff;
	logic              exp_due_ff = 1'b0;

	always @(negedge pel_clk)
	begin
		if (arst_n)
			chk("req_qual", {31'h0, video_out.qual_n}, {31'h0, ~exp_due_ff});
		if (arst_n && !video_out.qual_n)
			chk("data", {16'h0, video_out.data}, {16'h0, exp_word_ff});
		exp_due_ff  <= pixel_req;
		exp_word_ff <= pixel_data;
	end

	task automatic close_out;
		$display("mismatches %0d compares %0d", err_total, compares);
		if (err_total == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : close_out

	// external trigger held clean for five clocks, no glitches; with m set, a one-clock internal start pulse instead
	task automatic start_frame(input logic m);
		@(posedge clk) if (m) int_frame_start <= 1'b1; else frame_trig <= 1'b1;
		@(posedge clk) int_frame_start <= 1'b0;
		repeat (4) @(posedge clk);
		frame_trig <= 1'b0;
	endtask : start_frame

	initial
	begin
		#3_500_000;
		err_total++;
		close_out;
	end

	initial
	begin
		repeat (5) @(posedge clk);
		arst_n <= 1'b1;
		for (int m = 0; m < 2; m++)
		begin
			repeat (8) @(posedge pel_clk);
			@(posedge clk) full_res <= m[0];
			user_sync_en <= !m[0];
			repeat (4) @(posedge clk);
			start_frame(m[0]); // first of two starts per reset; the second lands two lines in and is ignored
			repeat (2 * exp_len(m[0])) @(posedge pel_clk);
			start_frame(m[0]);
			repeat (7 * exp_len(m[0]) + 100) @(posedge pel_clk);
			chk("line_len", line_len, exp_len(m[0]));
			chk("hs_low", hs_low, 8);
			chk("vs_lines", vs_lines, 4);
			chk("q_ofs", q_ofs, 15);
			chk("q_run", q_run, exp_pix(m[0]));
			chk("q_line", q_line, 8);
			chk("vs_falls", vs_falls, m + 1);
			chk("busy", {31'h0, frame_busy}, 1);
			@(posedge clk) arst_n <= 1'b0;
			repeat (3) @(posedge pel_clk);
			#1;
			chk("idle_bus", {13'h0, video_out}, {13'h0, 3'h7, 16'h0000});
			@(posedge clk) arst_n <= 1'b1;
		end
		close_out;
	end
endmodule : tb_top
